// ==== rtl/powerup_selftest_status.sv ====
// Functional notes
// - Panel shows the tests-in-progress message while power-up tests run.
// - LED goes off only after CPU, RAM, ROM and secondary link pass.
// - First step after reset turns the LED on.
// - Bad program ROM blinks the LED at one blink per second.
// - Failed RAM test blinks the LED at five blinks per second.
// - Secondary not executing after 30 seconds leaves LED steadily lit.
// - No handshake within 15 to 20 seconds shows the memory fault message.
// - Secondary writes shared RAM only when fully out of reset.
// - Secondary programs the memory controller as part of its handshake.
// - Secondary-to-mechanism failure keeps LED lit and tests message, judged at 20 s.
// - Mechanism link failure after passing tests shows the link fault message.
// - ROM check catches swapped devices and single or multiple bit errors.
`timescale 1ns/1ns
`default_nettype none

module powerup_selftest_status #(
  parameter int ROM_W = 16,
  parameter logic [selftest_pkg::TMR_W-1:0] SEC_DEAD_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::SEC_DEAD_CYC),
  parameter logic [selftest_pkg::TMR_W-1:0] SEC_MECH_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::SEC_MECH_CYC),
  parameter logic [selftest_pkg::TMR_W-1:0] HS_WAIT_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::HS_WAIT_CYC),
  parameter logic [selftest_pkg::TMR_W-1:0] MECH_LINK_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::MECH_LINK_CYC),
  parameter logic [selftest_pkg::TMR_W-1:0] ROM_BLINK_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::ROM_BLINK_CYC),
  parameter logic [selftest_pkg::TMR_W-1:0] RAM_BLINK_CYC =
    selftest_pkg::TMR_W'(selftest_pkg::RAM_BLINK_CYC)
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire selftest_pkg::result_t I_CPU_RESULT,
  input wire selftest_pkg::result_t I_RAM_RESULT,
  input wire logic I_ROM_VALID,
  input wire logic I_ROM_LAST,
  input wire logic [ROM_W-1:0] I_ROM_DATA,
  input wire logic [2*ROM_W-1:0] I_ROM_REF,
  input wire selftest_pkg::pins_t I_PINS,
  output selftest_pkg::status_t O_STATUS,
  output logic O_HANDSHAKE,
  output logic O_SEC_RST_N,
  output logic O_SEC_RAM_WE
);

  localparam int TW = selftest_pkg::TMR_W;
  localparam int NP = selftest_pkg::NUM_PINS;

  // Synchronised pins and the sequencer.
  logic [NP-1:0] pin_sync_reg;
  selftest_pkg::pins_t pins;
  selftest_pkg::state_t state_reg;
  selftest_pkg::state_t state_next;
  logic [TW-1:0] tmr_reg;
  logic [TW-1:0] hs_tmr_reg;
  logic hs_timeout_reg;
  // Blink generator.
  logic [TW-1:0] blink_cnt_reg;
  logic blink_reg;
  logic [TW-1:0] blink_half;
  // ROM check sums.
  logic [ROM_W-1:0] sum_lo_reg;
  logic [ROM_W-1:0] sum_hi_reg;
  logic [ROM_W-1:0] sum_lo_next;
  logic [ROM_W-1:0] sum_hi_next;
  logic rom_done_reg;
  logic rom_ok_reg;
  // Secondary reset hold and the registered outputs.
  logic [8:0] sec_hold_reg;
  logic sec_out_of_rst_reg;
  logic sec_ready;
  selftest_pkg::status_t status_reg;
  logic hs_reg;
  logic ram_we_reg;

  // Every pin passes two flip-flops; only the second stage is read.
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= I_PINS[g];
          sync_reg <= meta_reg;
        end
      end
      // Each lane drives only its own bit, so no bit has two writers.
      assign pin_sync_reg[g] = sync_reg;
    end
  endgenerate

  // The struct view names the lanes; bit order follows the package.
  assign pins = selftest_pkg::pins_t'(pin_sync_reg);

  // The ack only counts once the memory controller has been programmed.
  assign sec_ready = pins.sec_ack & pins.memctl_done;

  // Fletcher-style sums: the second sum weights each word by its position,
  // so swapped ROM devices change the result, not only flipped bits.
  assign sum_lo_next = sum_lo_reg + I_ROM_DATA;
  assign sum_hi_next = sum_hi_reg + sum_lo_next;

  // ROM word stream is only taken while the ROM test is running.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      sum_lo_reg <= '0;
      sum_hi_reg <= '0;
      rom_done_reg <= 1'b0;
      rom_ok_reg <= 1'b0;
    end else if (state_reg == selftest_pkg::ST_ROM && I_ROM_VALID && !rom_done_reg) begin
      sum_lo_reg <= sum_lo_next;
      sum_hi_reg <= sum_hi_next;
      if (I_ROM_LAST) begin
        rom_done_reg <= 1'b1;
        rom_ok_reg <= ({sum_hi_next, sum_lo_next} == I_ROM_REF);
      end
    end
  end

  // Sequencer of the power-up tests.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      selftest_pkg::ST_BOOT: begin
        state_next = selftest_pkg::ST_CPU;
      end
      selftest_pkg::ST_CPU: begin
        if (I_CPU_RESULT.done) begin
          state_next = I_CPU_RESULT.pass ? selftest_pkg::ST_RAM : selftest_pkg::ST_CPU_BAD;
        end
      end
      selftest_pkg::ST_RAM: begin
        if (I_RAM_RESULT.done) begin
          state_next = I_RAM_RESULT.pass ? selftest_pkg::ST_ROM : selftest_pkg::ST_RAM_BAD;
        end
      end
      selftest_pkg::ST_ROM: begin
        if (rom_done_reg) begin
          state_next = rom_ok_reg ? selftest_pkg::ST_LINK : selftest_pkg::ST_ROM_BAD;
        end
      end
      selftest_pkg::ST_LINK: begin
        if (sec_ready) begin
          state_next = selftest_pkg::ST_SEC_MECH;
        end else if (tmr_reg >= SEC_DEAD_CYC - 1'b1) begin
          state_next = selftest_pkg::ST_SEC_DEAD;
        end
      end
      selftest_pkg::ST_SEC_MECH: begin
        if (pins.sec_mech_ok) begin
          state_next = selftest_pkg::ST_MECH;
        end else if (tmr_reg >= SEC_MECH_CYC - 1'b1) begin
          state_next = selftest_pkg::ST_SEC_MECH_BAD;
        end
      end
      selftest_pkg::ST_MECH: begin
        if (pins.mech_link_ok) begin
          state_next = selftest_pkg::ST_RUN;
        end else if (tmr_reg >= MECH_LINK_CYC - 1'b1) begin
          state_next = selftest_pkg::ST_MECH_BAD;
        end
      end
      // Terminal states hold until the next board reset.
      selftest_pkg::ST_RUN, selftest_pkg::ST_ROM_BAD, selftest_pkg::ST_RAM_BAD,
      selftest_pkg::ST_SEC_DEAD, selftest_pkg::ST_SEC_MECH_BAD,
      selftest_pkg::ST_MECH_BAD, selftest_pkg::ST_CPU_BAD: begin
        state_next = state_reg;
      end
      // Unused codes fall into a fault state rather than wander.
      default: begin
        state_next = selftest_pkg::ST_CPU_BAD;
      end
    endcase
  end

  // State register; every reset lands in the boot step.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state_reg <= selftest_pkg::ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // State timer restarts on every change and saturates, so it never wraps.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || state_next != state_reg) begin
      tmr_reg <= '0;
    end else if (tmr_reg != {TW{1'b1}}) begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  // Secondary's own wait for the handshake, counted from board reset.
  // The flag is sticky: a late handshake clears the message, not the flag.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      hs_tmr_reg <= '0;
      hs_timeout_reg <= 1'b0;
    end else if (!hs_reg) begin
      if (hs_tmr_reg >= HS_WAIT_CYC - 1'b1) begin
        hs_timeout_reg <= 1'b1;
      end else begin
        hs_tmr_reg <= hs_tmr_reg + 1'b1;
      end
    end
  end

  // Handshake goes out once ROM passes and stays up as a level.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      hs_reg <= 1'b0;
    end else if (state_reg == selftest_pkg::ST_LINK) begin
      hs_reg <= 1'b1;
    end
  end

  // Hold the secondary in reset for a while so a short power dip cannot
  // leave it half reset and scribbling over shared RAM.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      sec_hold_reg <= '0;
      sec_out_of_rst_reg <= 1'b0;
    end else if (sec_hold_reg == 9'(selftest_pkg::SEC_RST_HOLD_CYC - 1)) begin
      sec_out_of_rst_reg <= 1'b1;
    end else begin
      sec_hold_reg <= sec_hold_reg + 1'b1;
    end
  end

  // Shared RAM writes pass only while the secondary is out of reset.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ram_we_reg <= 1'b0;
    end else begin
      ram_we_reg <= sec_out_of_rst_reg & pins.sec_ram_wr_req;
    end
  end

  // Blink half period follows the failing test.
  always_comb begin
    blink_half = (state_reg == selftest_pkg::ST_RAM_BAD) ? RAM_BLINK_CYC : ROM_BLINK_CYC;
  end

  // Counter and phase rest outside the blinking states, so every blink
  // pattern starts with the LED lit and a full half period.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || (state_reg != selftest_pkg::ST_ROM_BAD &&
                  state_reg != selftest_pkg::ST_RAM_BAD)) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b1;
    end else if (blink_cnt_reg >= blink_half - 1'b1) begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  // LED and panel message, registered so the pins never glitch.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      status_reg.led <= 1'b0;
      status_reg.msg <= selftest_pkg::MSG_TESTS;
      status_reg.state <= selftest_pkg::ST_BOOT;
    end else begin
      status_reg.state <= state_reg;
      unique case (state_reg)
        selftest_pkg::ST_ROM_BAD: status_reg.led <= blink_reg;
        selftest_pkg::ST_RAM_BAD: status_reg.led <= blink_reg;
        selftest_pkg::ST_MECH, selftest_pkg::ST_RUN, selftest_pkg::ST_MECH_BAD: begin
          status_reg.led <= 1'b0;
        end
        default: status_reg.led <= 1'b1;
      endcase
      // The memory fault message overrides the others until the handshake arrives.
      if (hs_timeout_reg && !hs_reg) begin
        status_reg.msg <= selftest_pkg::MSG_MEM_FAULT;
      end else if (state_reg == selftest_pkg::ST_MECH_BAD) begin
        status_reg.msg <= selftest_pkg::MSG_MECH_FAULT;
      end else if (state_reg == selftest_pkg::ST_RUN) begin
        status_reg.msg <= selftest_pkg::MSG_READY;
      end else begin
        status_reg.msg <= selftest_pkg::MSG_TESTS;
      end
    end
  end

  // Every output comes straight from a flip-flop.
  assign O_STATUS = status_reg;
  assign O_HANDSHAKE = hs_reg;
  assign O_SEC_RST_N = sec_out_of_rst_reg;
  assign O_SEC_RAM_WE = ram_we_reg;

endmodule

`default_nettype wire

// ==== rtl/selftest_pkg.sv ====
package selftest_pkg;

  // Clock rate of the board logic.
  localparam longint CLK_HZ = 250_000_000;

  // Times in milliseconds, as the operator sees them.
  localparam longint SEC_DEAD_MS = 30_000;
  localparam longint SEC_MECH_MS = 20_000;
  localparam longint HS_WAIT_MS = 15_000;
  localparam longint MECH_LINK_MS = 20_000;
  localparam longint ROM_BLINK_HALF_MS = 500;
  localparam longint RAM_BLINK_HALF_MS = 100;

  // Least times round up to whole cycles.
  localparam longint SEC_DEAD_CYC = (SEC_DEAD_MS * CLK_HZ + 999) / 1000;
  localparam longint SEC_MECH_CYC = (SEC_MECH_MS * CLK_HZ + 999) / 1000;
  localparam longint HS_WAIT_CYC = (HS_WAIT_MS * CLK_HZ + 999) / 1000;
  localparam longint MECH_LINK_CYC = (MECH_LINK_MS * CLK_HZ + 999) / 1000;
  // Blink half periods are nominal; a longest time rounds down.
  localparam longint ROM_BLINK_CYC = (ROM_BLINK_HALF_MS * CLK_HZ) / 1000;
  localparam longint RAM_BLINK_CYC = (RAM_BLINK_HALF_MS * CLK_HZ) / 1000;

  // Timer width covers well over the longest wait.
  localparam int TMR_W = 36;
  // Cycles the secondary processor is held in reset after board reset.
  localparam int SEC_RST_HOLD_CYC = 256;
  // Number of pin inputs passed through synchronisers.
  localparam int NUM_PINS = 5;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0000,
    ST_CPU = 4'b0001,
    ST_RAM = 4'b0010,
    ST_ROM = 4'b0011,
    ST_LINK = 4'b0100,
    ST_SEC_MECH = 4'b0101,
    ST_MECH = 4'b0110,
    ST_RUN = 4'b0111,
    ST_ROM_BAD = 4'b1000,
    ST_RAM_BAD = 4'b1001,
    ST_SEC_DEAD = 4'b1010,
    ST_SEC_MECH_BAD = 4'b1011,
    ST_MECH_BAD = 4'b1100,
    ST_CPU_BAD = 4'b1101
  } state_t;

  typedef enum logic [1:0] {
    MSG_TESTS = 2'b00,
    MSG_MEM_FAULT = 2'b01,
    MSG_MECH_FAULT = 2'b10,
    MSG_READY = 2'b11
  } msg_t;

  // Result of a test run by the main processor.
  typedef struct packed {
    logic done;
    logic pass;
  } result_t;

  // Pins from the secondary processor and the mechanism side.
  typedef struct packed {
    logic sec_ack;
    logic memctl_done;
    logic sec_mech_ok;
    logic mech_link_ok;
    logic sec_ram_wr_req;
  } pins_t;

  // What the operator sees, plus the sequencer state for diagnosis.
  typedef struct packed {
    logic led;
    msg_t msg;
    state_t state;
  } status_t;

endpackage

// ==== testbench/selftest_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
// Ties the status outputs to the test sequence and its timeouts.
module selftest_asserts #(
  parameter logic [35:0] SEC_DEAD_CYC = 36'h0001,
  parameter logic [35:0] SEC_MECH_CYC = 36'h0001,
  parameter logic [35:0] HS_WAIT_CYC = 36'h0001,
  parameter logic [35:0] MECH_LINK_CYC = 36'h0001,
  parameter logic [35:0] ROM_BLINK_CYC = 36'h0001,
  parameter logic [35:0] RAM_BLINK_CYC = 36'h0001
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire selftest_pkg::status_t O_STATUS,
  input wire logic O_HANDSHAKE,
  input wire logic O_SEC_RST_N,
  input wire logic O_SEC_RAM_WE
);
  logic [35:0] dwell;
  logic [35:0] run;
  logic [35:0] hsc;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  // Samples spent in the shown state, so a timeout is judged to the cycle.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || $changed(O_STATUS.state))
      dwell <= 36'h0001;
    else
      dwell <= dwell + 36'h0001;
  end
  // Samples since the LED or the state last moved.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || $changed(O_STATUS.state) || $changed(O_STATUS.led))
      run <= 36'h0001;
    else
      run <= run + 36'h0001;
  end
  // Freezes rather than clears, since the handshake never drops again.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST)
      hsc <= 36'h0000;
    else if (!O_HANDSHAKE)
      hsc <= hsc + 36'h0001;
  end
  AST_LED_ON_AT_BOOT:
    assert property ($fell(I_RST) |-> ##[1:3] O_STATUS.led)
    else $error("LED not lit after reset");
  AST_LED_OFF_ONLY_PASSED:
    assert property (!O_STATUS.led |-> O_STATUS.state inside {selftest_pkg::ST_BOOT,
      selftest_pkg::ST_MECH, selftest_pkg::ST_RUN, selftest_pkg::ST_MECH_BAD,
      selftest_pkg::ST_ROM_BAD, selftest_pkg::ST_RAM_BAD})
    else $error("LED off before tests passed");
  AST_ROM_BLINK:
    assert property (O_STATUS.state == selftest_pkg::ST_ROM_BAD
      |-> run <= ROM_BLINK_CYC + 36'h0001)
    else $error("ROM fault LED not blinking");
  AST_RAM_BLINK:
    assert property (O_STATUS.state == selftest_pkg::ST_RAM_BAD
      |-> run <= RAM_BLINK_CYC + 36'h0001)
    else $error("RAM fault LED not blinking");
  AST_SEC_DEAD_WAIT:
    assert property ($changed(O_STATUS.state) && O_STATUS.state == selftest_pkg::ST_SEC_DEAD
      |-> dwell == SEC_DEAD_CYC && $past(O_STATUS.state) == selftest_pkg::ST_LINK)
    else $error("secondary dead judged at wrong time");
  AST_STUCK_SHOWS_TESTS:
    assert property (O_STATUS.state inside {selftest_pkg::ST_SEC_DEAD,
      selftest_pkg::ST_SEC_MECH_BAD} |-> O_STATUS.led && O_STATUS.msg == selftest_pkg::MSG_TESTS)
    else $error("stuck state shows wrong LED or message");
  AST_SEC_MECH_WAIT:
    assert property ($changed(O_STATUS.state)
      && O_STATUS.state == selftest_pkg::ST_SEC_MECH_BAD |-> dwell == SEC_MECH_CYC)
    else $error("secondary mechanism fault at wrong time");
  AST_MECH_LINK_FAULT:
    assert property ($changed(O_STATUS.state) && O_STATUS.state == selftest_pkg::ST_MECH_BAD
      |-> dwell == MECH_LINK_CYC && !O_STATUS.led
      && O_STATUS.msg == selftest_pkg::MSG_MECH_FAULT)
    else $error("mechanism link fault wrong");
  AST_MEM_FAULT_SHOWN:
    assert property (!O_HANDSHAKE && hsc == HS_WAIT_CYC + 36'h0003
      |-> O_STATUS.msg == selftest_pkg::MSG_MEM_FAULT)
    else $error("memory fault message missing");
  AST_TESTS_MSG:
    assert property (O_STATUS.state inside {[selftest_pkg::ST_CPU:selftest_pkg::ST_SEC_MECH]}
      && hsc + 36'h0010 < HS_WAIT_CYC |-> O_STATUS.msg == selftest_pkg::MSG_TESTS)
    else $error("tests message missing");
  AST_RAM_WE_GATED:
    assert property (!O_SEC_RST_N |=> !O_SEC_RAM_WE)
    else $error("shared RAM write while secondary held");
  cover property (O_STATUS.state == selftest_pkg::ST_RUN);
  cover property (O_STATUS.state == selftest_pkg::ST_ROM_BAD && $changed(O_STATUS.led));
  cover property (O_STATUS.msg == selftest_pkg::MSG_MEM_FAULT);
endmodule
bind powerup_selftest_status selftest_asserts #(.SEC_DEAD_CYC(SEC_DEAD_CYC),
  .SEC_MECH_CYC(SEC_MECH_CYC), .HS_WAIT_CYC(HS_WAIT_CYC), .MECH_LINK_CYC(MECH_LINK_CYC),
  .ROM_BLINK_CYC(ROM_BLINK_CYC), .RAM_BLINK_CYC(RAM_BLINK_CYC)) u_chk (.I_SYS_CLK(I_SYS_CLK),
  .I_RST(I_RST), .O_STATUS(O_STATUS), .O_HANDSHAKE(O_HANDSHAKE),
  .O_SEC_RST_N(O_SEC_RST_N), .O_SEC_RAM_WE(O_SEC_RAM_WE));
`default_nettype wire

// ==== testbench/sec_proc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Secondary processor and mechanism side, answering fast or slow.
module sec_proc_model (
  input wire logic i_clk,
  input wire logic i_hs,
  input wire logic i_rst_n,
  input wire logic i_alive,
  input wire logic i_slow,
  input wire logic i_mech,
  input wire logic i_link,
  output selftest_pkg::pins_t o_pins
);
  logic [7:0] cnt_reg = 8'h00;
  logic tog_reg = 1'b0;
  wire logic [7:0] thr = i_slow ? 8'h30 : 8'h02;
  // The counter stays at zero before the handshake or while held in reset; the toggle always runs.
  always_ff @(posedge i_clk) begin
    if (!i_hs || !i_rst_n)
      cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hff)
      cnt_reg <= cnt_reg + 8'h01;
    tog_reg <= !tog_reg;
  end
  // Controller setup finishes before the ack is given.
  assign o_pins.memctl_done = i_alive && cnt_reg > thr;
  assign o_pins.sec_ack = i_alive && cnt_reg > thr + 8'h02;
  assign o_pins.sec_mech_ok = o_pins.sec_ack && i_mech;
  assign o_pins.mech_link_ok = o_pins.sec_mech_ok && i_link;
  // A part not fully reset leaves its write line wandering.
  assign o_pins.sec_ram_wr_req = i_rst_n ? cnt_reg[1] : tog_reg;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [35:0] DEAD = 36'h0140;
  localparam logic [35:0] SMECH = 36'h0096;
  localparam logic [35:0] MLINK = 36'h0064;
  localparam logic [35:0] ROMB = 36'h000a;
  localparam logic [35:0] RAMB = 36'h0004;
  logic clk = 1'b0;
  logic rst = 1'b1;
  selftest_pkg::result_t cpu = '0;
  selftest_pkg::result_t ram = '0;
  logic rv = 1'b0;
  logic rl = 1'b0;
  logic [15:0] rd = 16'h0000;
  logic [31:0] rref = 32'h0000_0000;
  logic [3:0] far = 4'hf;
  selftest_pkg::pins_t pins;
  selftest_pkg::status_t st;
  logic hs;
  logic srn;
  logic we;
  logic [15:0] rom [3] = '{16'h1234, 16'h00ff, 16'hbeef};
  int bad_count = 0;
  int checks_done = 0;
  powerup_selftest_status #(.SEC_DEAD_CYC(DEAD), .SEC_MECH_CYC(SMECH),
    .HS_WAIT_CYC(36'h012c), .MECH_LINK_CYC(MLINK), .ROM_BLINK_CYC(ROMB),
    .RAM_BLINK_CYC(RAMB)) uut (.I_SYS_CLK(clk), .I_RST(rst), .I_CPU_RESULT(cpu),
    .I_RAM_RESULT(ram), .I_ROM_VALID(rv), .I_ROM_LAST(rl), .I_ROM_DATA(rd),
    .I_ROM_REF(rref), .I_PINS(pins), .O_STATUS(st), .O_HANDSHAKE(hs),
    .O_SEC_RST_N(srn), .O_SEC_RAM_WE(we));
  sec_proc_model far_side (.i_clk(clk), .i_hs(hs), .i_rst_n(srn), .i_alive(far[3]),
    .i_slow(far[2]), .i_mech(far[1]), .i_link(far[0]), .o_pins(pins));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bounded wait for a shown state; n is the number of cycles it took.
  task automatic wait_st(input selftest_pkg::state_t s, input int lim, output int n);
    n = 0;
    while (st.state !== s && n < lim) begin
      tick();
      n++;
    end
    if (st.state !== s) begin
      bad_count++;
      $display("MISMATCH %0t state %0d not reached", $time, s);
      final_report();
    end
  endtask
  task automatic pulse_rst();
    rst = 1'b1;
    tick();
    tick();
    rst = 1'b0;
  endtask
  // Resets and runs CPU, RAM and ROM steps; sw feeds the ROM words reversed.
  task automatic boot(input logic rp, input logic sw);
    int n;
    cpu = 2'b11;
    ram = {1'b1, rp};
    pulse_rst();
    repeat (3) tick();
    chk(st.led === 1'b1, "LED dark after reset");
    chk(st.msg === selftest_pkg::MSG_TESTS, "no tests message");
    if (rp) begin
      wait_st(selftest_pkg::ST_ROM, 10, n);
      for (int i = 0; i < 3; i++) begin
        rv = 1'b1;
        rd = rom[sw ? 2 - i : i];
        rl = (i == 2);
        tick();
      end
      rv = 1'b0;
      rl = 1'b0;
    end
  endtask
  // Skips the first LED edge, then times one whole half period.
  task automatic blink(input logic [35:0] half);
    int n;
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = st.led;
      n = 0;
      while (st.led === v && n < 40) begin
        tick();
        n++;
      end
    end
    chk(36'(n) === half, "blink half period wrong");
  endtask
  task automatic stuck(input selftest_pkg::state_t a, input selftest_pkg::state_t b,
      input logic [35:0] cyc);
    int n;
    wait_st(a, 400, n);
    wait_st(b, 400, n);
    chk(36'(n) === cyc, "timeout length wrong");
  endtask
  // Fast secondary here; the stuck scenarios use the slow one.
  task automatic t_pass();
    int n;
    far = 4'hb;
    boot(1'b1, 1'b0);
    wait_st(selftest_pkg::ST_RUN, 300, n);
    chk(st.led === 1'b0, "LED lit in run");
    chk(hs === 1'b1 && st.msg === selftest_pkg::MSG_READY, "not ready");
  endtask
  // CPU never reports, so the handshake never comes.
  task automatic t_stall();
    int n;
    int up;
    cpu = 2'b00;
    pulse_rst();
    n = 0;
    up = 0;
    while (st.msg !== selftest_pkg::MSG_MEM_FAULT && n < 400) begin
      if (srn !== 1'b1) begin
        up = n + 1;
        chk(we === 1'b0, "shared RAM write while held");
      end
      tick();
      n++;
    end
    chk(up >= 255 && up <= 258, "secondary reset hold");
    chk(n >= 296 && n <= 304 && hs === 1'b0, "memory fault timing");
    repeat (4) tick();
    chk(st.msg === selftest_pkg::MSG_MEM_FAULT, "memory fault not held");
  endtask
  // CPU self-test fails, so the LED must never go dark.
  task automatic t_cpubad();
    int n;
    cpu = 2'b10;
    pulse_rst();
    wait_st(selftest_pkg::ST_CPU_BAD, 10, n);
    repeat (20) tick();
    chk(st.led === 1'b1 && hs === 1'b0, "CPU fault LED or handshake");
  endtask
  task automatic t_rombad();
    int n;
    boot(1'b1, 1'b1);
    wait_st(selftest_pkg::ST_ROM_BAD, 20, n);
    blink(ROMB);
  endtask
  task automatic t_rambad();
    int n;
    boot(1'b0, 1'b0);
    wait_st(selftest_pkg::ST_RAM_BAD, 10, n);
    blink(RAMB);
  endtask
  task automatic t_dead();
    far = 4'h7;
    boot(1'b1, 1'b0);
    stuck(selftest_pkg::ST_LINK, selftest_pkg::ST_SEC_DEAD, DEAD);
    chk(st.led === 1'b1 && st.msg === selftest_pkg::MSG_TESTS, "dead shown");
  endtask
  task automatic t_secmech();
    far = 4'hd;
    boot(1'b1, 1'b0);
    stuck(selftest_pkg::ST_SEC_MECH, selftest_pkg::ST_SEC_MECH_BAD, SMECH);
    chk(st.led === 1'b1 && st.msg === selftest_pkg::MSG_TESTS, "stuck shown");
  endtask
  task automatic t_mech();
    far = 4'he;
    boot(1'b1, 1'b0);
    stuck(selftest_pkg::ST_MECH, selftest_pkg::ST_MECH_BAD, MLINK);
    chk(st.led === 1'b0 && st.msg === selftest_pkg::MSG_MECH_FAULT, "link fault");
  endtask
  initial begin
    logic [15:0] lo;
    logic [15:0] hi;
    lo = 16'h0000;
    hi = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      lo = lo + rom[i];
      hi = hi + lo;
    end
    rref = {hi, lo};
    repeat (12) tick();
    t_pass();
    t_stall();
    t_rombad();
    t_rambad();
    t_dead();
    t_secmech();
    t_mech();
    t_cpubad();
    final_report();
  end
endmodule
`default_nettype wire
